/* rtl/dvso_pkg.sv */
package dvso_pkg;
    // timing base
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SH_RATE_HZ    = 40_000;
    localparam int unsigned FRAME_CYC     = CLK_HZ / SH_RATE_HZ;
    localparam int unsigned HALF_CYC      = FRAME_CYC / 2;
    // track window inside each slot, least times so rounded up
    localparam int unsigned SETTLE_NS     = 1000;
    localparam int unsigned TRACK_NS      = 2000;
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TRACK_CYC     = (TRACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // slave lands two edges after the master sync pulse
    localparam logic [11:0] SYNC_ALIGN    = 12'h002;
    localparam logic [11:0] FRAME_LAST    = 12'(FRAME_CYC - 1);
    localparam logic [11:0] MASTER_START  = 12'h000;
    localparam logic [11:0] SLAVE_START   = 12'(HALF_CYC);
    // gain codes 0..4 pick channels; 5..7 are reserved
    localparam logic [2:0]  GAIN_MAX      = 3'h4;
    localparam logic [2:0]  GAIN_RST      = 3'h0;
    localparam logic [11:0] SAMPLE_RST    = 12'h000;
    // status byte bit positions
    localparam int unsigned ST_EMPTY      = 0;
    localparam int unsigned ST_FULL       = 1;
    localparam int unsigned ST_HIGH_NEXT  = 2;
    localparam int unsigned ST_MASTER     = 3;
    localparam int unsigned ST_OWN_SLOT   = 4;
    localparam int unsigned ST_RSVD_GAIN  = 5;
    localparam int unsigned BUF_DEPTH     = 2;

    typedef struct packed {
        logic [2:0]  gain;
        logic [11:0] word;
    } dvso_sample_t;
endpackage

/* rtl/dvso_port.sv */
`timescale 1ns/1ps
// What this block does
// R1 - 8-bit shared bus, driven only on reads
// R2 - select high means bus activity ignored
// R3 - select and read low drive status
// R4 - write enable low marks write cycle
// R5 - data captured on strobe rising edge
// R6 - role input: high master, low slave
// R7 - sync pin driven by master, followed by slave
// R8 - single clock runs all sequencing
// R9 - reset initialises all internal state except the buffer storage
// R10 - master drives in slot high, slave low
// R11 - sample presented as 12-bit word
// R12 - 40 kHz sample-hold pulse per generator
// R13 - pulse high tracks, low holds value
// R14 - slave pulse drives its own path
// R15 - gain code selects one of five
// R16 - codes 0-4 used, 5-7 reserved
module dvso_port
    import dvso_pkg::*;
(
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    // host bus
    input  wire logic [7:0]  i_host_bus,
    output logic      [7:0]  o_host_bus,
    output logic             o_host_bus_oe_b,
    input  wire logic        i_cs_b,
    input  wire logic        i_rd_b,
    input  wire logic        i_we_b,
    input  wire logic        i_write_latch_strobe,
    output logic             o_wr_ready,
    // role and sync
    input  wire logic        i_master,
    input  wire logic        i_sync_line,
    output logic             o_sync_line,
    output logic             o_sync_line_oe_b,
    input  wire logic        i_output_slot_select,
    output logic             o_output_slot_select,
    output logic             o_output_slot_select_oe_b,
    // dac side
    output logic      [11:0] o_sample_word,
    output logic             o_sample_word_oe_b,
    output logic      [2:0]  o_gain_range_code,
    output logic             o_sample_hold_pulse
);

    logic              role_ff;
    logic              strobe_prev_ff;
    logic              sync_prev_ff;
    logic              byte_hi_ff;
    logic [7:0]        lo_byte_ff;
    logic [11:0]       frame_cnt_ff;
    logic [11:0]       nxt_frame_cnt;
    dvso_sample_t      buf_mem [BUF_DEPTH];
    logic              wr_ptr_ff;
    logic              rd_ptr_ff;
    logic [1:0]        fill_ff;
    logic [1:0]        nxt_fill;
    logic              rsvd_seen_ff;
    logic              wr_edge;
    logic              push;
    logic              pop;
    logic              own_slot;
    dvso_sample_t      in_sample;
    dvso_sample_t      head;

    // true when count sits inside the track window of a slot
    function automatic logic in_track(input logic [11:0] cnt, input logic [11:0] start);
        logic [11:0] lo;
        logic [11:0] hi;
        lo = start + 12'(SETTLE_CYC);
        hi = lo + 12'(TRACK_CYC);
        return (cnt >= lo) && (cnt < hi);
    endfunction

    // write strobe edge, only while selected with write enable low
    assign wr_edge  = i_write_latch_strobe && !strobe_prev_ff && !i_cs_b && !i_we_b; // R2 R4 R5
    assign in_sample = '{gain: i_host_bus[6:4], word: {i_host_bus[3:0], lo_byte_ff}};
    assign push     = wr_edge && byte_hi_ff && (fill_ff != 2'(BUF_DEPTH));
    assign pop      = (frame_cnt_ff == (role_ff ? MASTER_START : SLAVE_START)) && (fill_ff != 2'h0);
    assign head     = buf_mem[rd_ptr_ff];
    assign own_slot = role_ff ? (frame_cnt_ff < SLAVE_START) : !i_output_slot_select; // R10

    // role strap caught by a clocked process after release
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            role_ff <= 1'b0; // R9
        end else if (i_ce) begin
            role_ff <= i_master; // R6
        end
    end

    // edge history of strobe and sync
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strobe_prev_ff <= 1'b0;
            sync_prev_ff   <= 1'b0;
        end else if (i_ce) begin
            strobe_prev_ff <= i_write_latch_strobe;
            sync_prev_ff   <= i_sync_line;
        end
    end

    // byte pairing: low byte first, then {x, gain, word[11:8]}
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            byte_hi_ff <= 1'b0;
            lo_byte_ff <= 8'h00;
        end else if (i_ce && wr_edge) begin
            if (!byte_hi_ff) begin
                lo_byte_ff <= i_host_bus; // R5
            end
            // a refused high byte still ends the pair to stay aligned
            byte_hi_ff <= !byte_hi_ff;
        end
    end

    // two-entry buffer so a busy dac slot loses no word until both entries are full
    always_comb begin
        nxt_fill = fill_ff;
        if (push && !pop) begin
            nxt_fill = fill_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_fill = fill_ff - 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_ff  <= 1'b0;
            rd_ptr_ff  <= 1'b0;
            fill_ff    <= 2'h0;
            o_wr_ready <= 1'b0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr_ff <= !wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= !rd_ptr_ff;
            end
            fill_ff    <= nxt_fill;
            o_wr_ready <= (nxt_fill != 2'(BUF_DEPTH));
        end
    end

    // storage has no reset; entries are only read after a push
    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            buf_mem[wr_ptr_ff] <= in_sample;
        end
    end

    // host read: status byte while select and read are low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_host_bus      <= 8'h00;
            o_host_bus_oe_b <= 1'b1;
        end else if (i_ce) begin
            o_host_bus_oe_b <= i_cs_b || i_rd_b; // R1 R2 R3
            o_host_bus      <= 8'h00;
            o_host_bus[ST_EMPTY]     <= (fill_ff == 2'h0);
            o_host_bus[ST_FULL]      <= (fill_ff == 2'(BUF_DEPTH));
            o_host_bus[ST_HIGH_NEXT] <= byte_hi_ff;
            o_host_bus[ST_MASTER]    <= role_ff;
            o_host_bus[ST_OWN_SLOT]  <= own_slot;
            o_host_bus[ST_RSVD_GAIN] <= rsvd_seen_ff;
        end
    end

    // frame counter; the slave realigns on each sync rising edge
    always_comb begin
        nxt_frame_cnt = (frame_cnt_ff == FRAME_LAST) ? 12'h000 : frame_cnt_ff + 12'h001;
        if (!role_ff && i_sync_line && !sync_prev_ff) begin
            nxt_frame_cnt = SYNC_ALIGN; // R7
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frame_cnt_ff <= 12'h000;
        end else if (i_ce) begin
            frame_cnt_ff <= nxt_frame_cnt; // R8
        end
    end

    // sync and slot pins: master drives, slave listens
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sync_line               <= 1'b0;
            o_sync_line_oe_b          <= 1'b1;
            o_output_slot_select      <= 1'b0;
            o_output_slot_select_oe_b <= 1'b1;
        end else if (i_ce) begin
            o_sync_line_oe_b          <= !role_ff; // R7
            o_sync_line               <= role_ff && (frame_cnt_ff == 12'h000); // R7
            o_output_slot_select_oe_b <= !role_ff;
            o_output_slot_select      <= role_ff && (frame_cnt_ff < SLAVE_START); // R10
        end
    end

    // sample and gain update once per frame at slot start
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sample_word     <= SAMPLE_RST;
            o_gain_range_code <= GAIN_RST;
            rsvd_seen_ff      <= 1'b0;
        end else if (i_ce && pop) begin
            o_sample_word <= head.word; // R11
            // reserved codes keep the last gain rather than open no channel
            if (head.gain <= GAIN_MAX) begin
                o_gain_range_code <= head.gain; // R15 R16
            end else begin
                rsvd_seen_ff <= 1'b1; // R16
            end
        end
    end

    // dac drive window and sample-hold track pulse
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sample_word_oe_b  <= 1'b1;
            o_sample_hold_pulse <= 1'b0;
        end else if (i_ce) begin
            o_sample_word_oe_b  <= !own_slot; // R10
            // window sits after settle, so the glitch at slot start is held off
            o_sample_hold_pulse <= in_track(frame_cnt_ff, role_ff ? MASTER_START : SLAVE_START); // R12 R13 R14
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    chk_read_drive: assert property (i_ce && !i_cs_b && !i_rd_b |=> !o_host_bus_oe_b) // R3
        else $error("bus not driven during read");
    chk_bus_release: assert property (i_ce && (i_cs_b || i_rd_b) |=> o_host_bus_oe_b) // R1
        else $error("bus driven outside read");
    chk_cs_ignore: assert property (i_ce && i_cs_b |=> $stable(byte_hi_ff) && !$rose(fill_ff == 2'h2)) // R2
        else $error("write taken while deselected");
    chk_low_capture: assert property (wr_edge && i_ce && !byte_hi_ff |=> lo_byte_ff == $past(i_host_bus)) // R4 R5
        else $error("low byte not captured on strobe");
    chk_sync_dir: assert property (o_sync_line_oe_b == !$past(role_ff) || $past(!i_ce)) // R7
        else $error("sync direction wrong for role");
    chk_sync_pulse: assert property (i_ce && role_ff && frame_cnt_ff == 12'h000 |=> o_sync_line) // R7
        else $error("master sync pulse missing");
    chk_master_slot: assert property (role_ff && $past(role_ff) && $past(i_ce) |-> o_sample_word_oe_b == !o_output_slot_select) // R10
        else $error("master drives outside its slot");
    chk_slave_slot: assert property (i_ce && !role_ff |=> o_sample_word_oe_b == $past(i_output_slot_select)) // R10
        else $error("slave drives outside its slot");
    chk_sh_start: assert property ($rose(o_sample_hold_pulse) |-> $past(frame_cnt_ff) ==
            (role_ff ? MASTER_START : SLAVE_START) + 12'(SETTLE_CYC)) // R12 R13
        else $error("track pulse starts at wrong count");
    chk_sh_frame: assert property (i_ce && frame_cnt_ff == FRAME_LAST && !role_ff |-> nxt_frame_cnt != 12'h001) // R12
        else $error("frame does not wrap to zero");
    chk_slave_path: assert property (!role_ff && o_sample_hold_pulse |-> o_output_slot_select_oe_b) // R14
        else $error("slave tracks while driving slot pin");
    chk_gain_range: assert property (o_gain_range_code <= GAIN_MAX) // R15 R16
        else $error("reserved gain code on output");

    cov_pair_push: cover property (push);
    cov_full_stall: cover property (fill_ff == 2'h2 ##1 pop);
    cov_rsvd_gain: cover property ($rose(rsvd_seen_ff));
    cov_slave_sync: cover property (!role_ff && i_sync_line && !sync_prev_ff);

endmodule // dvso_port

/* dv/dvso_host.sv */
`timescale 1ns/1ps
// sub-processor model on the shared byte bus
module dvso_host (
    // clock and resolved bus
    input  wire logic       i_clk,
    input  wire logic [7:0] i_host_bus,
    input  wire logic       i_host_bus_oe_b,
    // strobes and write data
    output logic      [7:0] o_data,
    output logic            o_cs_b,
    output logic            o_rd_b,
    output logic            o_we_b,
    output logic            o_write_latch_strobe
);
    // idle: deselected, strobes released
    initial begin
        o_data = 8'h00;
        o_cs_b = 1'b1;
        o_rd_b = 1'b1;
        o_we_b = 1'b1;
        o_write_latch_strobe = 1'b0;
    end
    // one byte; data stays put across the strobe rise and one edge past
    task automatic put_byte(input logic [7:0] d, input logic sel_b);
        @(posedge i_clk);
        o_cs_b <= sel_b;
        o_we_b <= 1'b0;
        o_data <= d;
        @(posedge i_clk);
        o_write_latch_strobe <= 1'b1;
        @(posedge i_clk);
        o_write_latch_strobe <= 1'b0;
        @(posedge i_clk);
        o_cs_b <= 1'b1;
        o_we_b <= 1'b1;
        o_data <= ~d; // released line must not keep the old byte
    endtask
    // low byte first, then gain and top nibble
    task automatic put_word(input logic [11:0] w, input logic [2:0] g, input logic sel_b);
        put_byte(w[7:0], sel_b);
        put_byte({1'b0, g, w[11:8]}, sel_b);
    endtask
    // hold the read until the enable is seen low, bounded
    task automatic get_status(output logic [7:0] st, output logic ok);
        ok = 1'b0;
        st = 8'h00;
        @(posedge i_clk);
        o_cs_b <= 1'b0;
        o_rd_b <= 1'b0;
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge i_clk);
            ok = (i_host_bus_oe_b === 1'b0);
            st = i_host_bus;
        end
        o_cs_b <= 1'b1;
        o_rd_b <= 1'b1;
    endtask
endmodule // dvso_host

/* dv/test_dvso_port.sv */
`timescale 1ns/1ps
module test_dvso_port;
    import dvso_pkg::*;
    logic        clk, rst_b, ce, master, sync_in, slot_in, cs_b, rd_b, we_b, wls, ok;
    logic        bus_oe_b, wr_ready, sync_o, sync_oe_b, slot_o, slot_oe_b, word_oe_b, shp;
    logic [7:0]  hdat, bus, dut_bus, st;
    logic [11:0] word;
    logic [2:0]  gain;
    int          err_count = 0;
    int          n_compared = 0;
    // resolved bus: the port wins only while it enables
    assign bus = (bus_oe_b === 1'b0) ? dut_bus : hdat;
    dvso_port i_dvso_port (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_host_bus(bus),
        .o_host_bus(dut_bus), .o_host_bus_oe_b(bus_oe_b), .i_cs_b(cs_b), .i_rd_b(rd_b),
        .i_we_b(we_b), .i_write_latch_strobe(wls), .o_wr_ready(wr_ready), .i_master(master),
        .i_sync_line(sync_in), .o_sync_line(sync_o), .o_sync_line_oe_b(sync_oe_b),
        .i_output_slot_select(slot_in), .o_output_slot_select(slot_o),
        .o_output_slot_select_oe_b(slot_oe_b), .o_sample_word(word),
        .o_sample_word_oe_b(word_oe_b), .o_gain_range_code(gain), .o_sample_hold_pulse(shp));
    dvso_host i_dvso_host (.i_clk(clk), .i_host_bus(bus), .i_host_bus_oe_b(bus_oe_b),
        .o_data(hdat), .o_cs_b(cs_b), .o_rd_b(rd_b), .o_we_b(we_b), .o_write_latch_strobe(wls));
    // free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] m, input logic [7:0] e);
        i_dvso_host.get_status(st, ok);
        chk("read_ack", 12'h001, {11'h0, ok});
        if (!ok) final_report();
        chk(nm, {4'h0, e}, {4'h0, st & m});
    endtask
    // bounded wait for the master frame pulse, then let two edges land
    task automatic wait_sync;
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 3000 && !hit; n++) begin
            @(posedge clk);
            hit = (sync_o === 1'b1);
        end
        chk("sync_seen", 12'h001, {11'h0, hit});
        if (!hit) final_report();
        repeat (2) @(posedge clk);
    endtask
    task automatic do_reset(input logic m);
        rst_b <= 1'b0;
        master <= m;
        repeat (5) @(posedge clk);
        chk("rst_oe_b", 12'h001, {11'h0, bus_oe_b});
        chk("rst_ready", 12'h000, {11'h0, wr_ready});
        chk("rst_word", SAMPLE_RST, word);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic sc_read_idle;
        do_reset(1'b1);
        rd_chk("status_master", 8'hEF, 8'h09);
        repeat (3) @(posedge clk);
        chk("released", 12'h001, {11'h0, bus_oe_b});
    endtask
    task automatic sc_deselect;
        i_dvso_host.put_word(12'hABC, 3'h1, 1'b1);
        rd_chk("status_ignored", 8'hEF, 8'h09);
    endtask
    // every gain code, then a reserved one that must leave gain alone
    task automatic sc_gains;
        for (int g = 0; g < 6; g++) begin
            i_dvso_host.put_word(12'h5A0 + 12'(g), 3'(g), 1'b0);
            wait_sync();
            wait_sync();
            chk("word", 12'h5A0 + 12'(g), word);
            chk("gain", (g > 4) ? 12'(GAIN_MAX) : 12'(g), {9'h0, gain});
        end
        rd_chk("rsvd_seen", 8'h20, 8'h20);
    endtask
    // two words fill the buffer; the third is dropped
    task automatic sc_fill;
        wait_sync();
        i_dvso_host.put_word(12'h111, 3'h0, 1'b0);
        i_dvso_host.put_word(12'h222, 3'h2, 1'b0);
        i_dvso_host.put_word(12'h333, 3'h3, 1'b0);
        chk("full_ready", 12'h000, {11'h0, wr_ready});
        rd_chk("full_bits", 8'h03, 8'h02);
        wait_sync();
        chk("pop1", 12'h111, word);
        wait_sync();
        chk("pop2", 12'h222, word);
        wait_sync();
        chk("gain2", 12'h002, {9'h0, gain});
        chk("no_pop3", 12'h222, word);
        rd_chk("empty_bits", 8'h03, 8'h01);
    endtask
    // one frame of pins counted cycle by cycle
    task automatic sc_frame(input logic [11:0] e_sync, input logic [11:0] e_slot);
        logic [11:0] sh, own, sy, sl;
        sh = 12'h000;
        own = 12'h000;
        sy = 12'h000;
        sl = 12'h000;
        repeat (FRAME_CYC) begin
            @(posedge clk);
            sh = sh + 12'(shp);
            own = own + 12'(!word_oe_b);
            sy = sy + 12'(sync_o);
            sl = sl + 12'(slot_o);
        end
        chk("track_cycles", 12'(TRACK_CYC), sh);
        chk("own_cycles", 12'(HALF_CYC), own);
        chk("sync_pulses", e_sync, sy);
        chk("slot_cycles", e_slot, sl);
    endtask
    // stands in for the master: sync pulse, then its slot pin high half a frame
    task automatic model_frame;
        sync_in <= 1'b1;
        slot_in <= 1'b1;
        @(posedge clk);
        sync_in <= 1'b0;
        repeat (HALF_CYC - 1) @(posedge clk);
        slot_in <= 1'b0;
        repeat (FRAME_CYC - HALF_CYC) @(posedge clk);
    endtask
    // slave owns the dac only while the master's slot pin is low
    task automatic sc_slave;
        do_reset(1'b0);
        model_frame();
        fork
            repeat (2) model_frame();
            begin
                rd_chk("status_slave", 8'hEF, 8'h01);
                chk("sync_oe_b", 12'h001, {11'h0, sync_oe_b});
                chk("slot_oe_b", 12'h001, {11'h0, slot_oe_b});
                sc_frame(12'h000, 12'h000);
            end
        join
    endtask
    // main sequence
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        master = 1'b1;
        sync_in = 1'b0;
        slot_in = 1'b0;
        sc_read_idle();
        sc_deselect();
        sc_gains();
        sc_fill();
        sc_frame(12'h001, 12'(HALF_CYC));
        sc_slave();
        final_report();
    end
endmodule // test_dvso_port
